// file: sbl_pkg.sv
// package: constants and carriers for the serial bootstrap loader
// assumes one 20 MHz clock domain and an AXI4-Lite register master
package sbl_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_LEN = 8'h08;
  localparam logic [7:0] ADDR_ENTRY = 8'h0c;
  localparam logic [7:0] ADDR_CFG = 8'h10;
  // control register fields
  localparam int CTRL_MDA = 0;
  localparam int CTRL_SPECIAL_MODE_BIT = 1;
  localparam int CTRL_BOOT_ROM_ENABLE_BIT = 2;
  localparam int CTRL_XBUS = 3;
  // status register fields
  localparam int STAT_BOOT = 0;
  localparam int STAT_FAST = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_RUN = 3;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // serial timing
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_FAST = 7812;
  localparam int BAUD_SLOW = 1200;
  localparam int BIT_FAST = (CLK_HZ + BAUD_FAST / 2) / BAUD_FAST;
  localparam int BIT_SLOW = (CLK_HZ + BAUD_SLOW / 2) / BAUD_SLOW;
  localparam int CNT_W = 16;
  // reset values
  localparam logic [7:0] CFG_RESET = 8'h0f;
  localparam logic [15:0] VEC_NORMAL = 16'hfffe;
  localparam int VEC_A14 = 14;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  // mode bits carried together
  typedef struct packed {
    logic xbus;
    logic boot_rom_enable_bit;
    logic special_mode_bit;
    logic expanded_select_bit;
  } sbl_mode_t;
  // loader sequence
  typedef enum logic [2:0] {
    SBL_VEC, SBL_INIT, SBL_BAUD, SBL_LOAD, SBL_JUMP, SBL_RUN
  } sbl_state_t;
endpackage

// file: sbl_loader.sv
// serial bootstrap loader with mode latch and axi4-lite registers
// assumes mode pins and serial line are asynchronous pins
//
// Overview of operation
// - bootstrap reset takes its vector from the boot rom
// - serial receiver is initialised before any download byte
// - first all-ones character selects one of two baud rates
// - program bytes received serially are stored in internal ram
// - after the download a jump passes control to ram
// - bootstrap mode is privileged and unlocks protected bits
// - software may change the mode bits in bootstrap mode
// - software may enable the expansion bus after bootstrap reset
// - config register is writable only in special modes
// - expanded select latched from low mode pin at reset release
// - special bit is inverse of high mode pin; with select 0 boots
// - boot rom enable resets to 1 only in bootstrap, else 0
// - special mode forces address bit 14 low on vector fetch
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module sbl_loader #(
  parameter int RAM_DEPTH = 256,
  parameter int AW = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mode_pin_low,
  input wire logic mode_pin_high,
  input wire logic serial_rx,
  input wire logic vec_fetch,
  input wire logic [15:0] cpu_addr,
  output logic [15:0] mem_addr,
  output logic [15:0] entry_addr,
  output logic jump_pulse,
  output logic xbus_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] ma_sync_reg, mb_sync_reg, rx_sync_reg;
  // two flops per pin before any logic
  always_ff @(posedge aclk)
  begin
    ma_sync_reg <= {ma_sync_reg[0], mode_pin_low};
    mb_sync_reg <= {mb_sync_reg[0], mode_pin_high};
    rx_sync_reg <= {rx_sync_reg[0], serial_rx};
  end
  wire logic rx = rx_sync_reg[1];

  // ****************************************
  // mode latch
  // ****************************************
  sbl_pkg::sbl_mode_t mode_reg;
  logic [7:0] cfg_reg;
  logic latched_reg;
  logic wr_go;
  logic [7:0] wr_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  // catch pins at first edge after release, then software owns bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= '0;
      latched_reg <= 1'b0;
    end
    else if (!latched_reg)
    begin
      latched_reg <= 1'b1;
      mode_reg.expanded_select_bit <= ma_sync_reg[1];
      mode_reg.special_mode_bit <= ~mb_sync_reg[1];
      mode_reg.boot_rom_enable_bit <= ~mb_sync_reg[1] & ~ma_sync_reg[1];
      mode_reg.xbus <= ma_sync_reg[1];
    end
    else if (wr_go && wr_addr_reg == sbl_pkg::ADDR_CTRL && wstrb_reg[0])
    begin
      if (mode_reg.special_mode_bit)
      begin
        mode_reg.expanded_select_bit <= wdata_reg[sbl_pkg::CTRL_MDA];
        mode_reg.special_mode_bit <= wdata_reg[sbl_pkg::CTRL_SPECIAL_MODE_BIT];
        mode_reg.boot_rom_enable_bit <= wdata_reg[sbl_pkg::CTRL_BOOT_ROM_ENABLE_BIT];
      end
      else
        mode_reg.boot_rom_enable_bit <= 1'b0;
      if (mode_reg.special_mode_bit || mode_reg.expanded_select_bit)
        mode_reg.xbus <= wdata_reg[sbl_pkg::CTRL_XBUS];
    end
  end
  assign xbus_en = mode_reg.xbus;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cfg_reg <= sbl_pkg::CFG_RESET;
    else if (wr_go && wr_addr_reg == sbl_pkg::ADDR_CFG && wstrb_reg[0]
             && mode_reg.special_mode_bit)
      cfg_reg <= wdata_reg[7:0];
  end

  // ****************************************
  // loader sequence and receiver
  // ****************************************
  sbl_pkg::sbl_state_t state_reg;
  logic fast_reg, rx_busy_reg, byte_ok;
  logic [sbl_pkg::CNT_W-1:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] len_reg;
  logic [7:0] ram [RAM_DEPTH];
  wire logic [sbl_pkg::CNT_W-1:0] bit_len = fast_reg ?
    sbl_pkg::CNT_W'(sbl_pkg::BIT_FAST) : sbl_pkg::CNT_W'(sbl_pkg::BIT_SLOW);
  // receiver: sample mid-bit, 10 samples per frame
  always_ff @(posedge aclk)
  begin
    byte_ok <= 1'b0;
    if (!aresetn || state_reg == sbl_pkg::SBL_INIT)
    begin
      rx_busy_reg <= 1'b0;
      cnt_reg <= '0;
      bit_reg <= '0;
      shift_reg <= '0;
    end
    else if (!rx_busy_reg)
    begin
      if (!rx && (state_reg == sbl_pkg::SBL_BAUD ||
                  state_reg == sbl_pkg::SBL_LOAD))
      begin
        rx_busy_reg <= 1'b1;
        cnt_reg <= bit_len >> 1;
        bit_reg <= '0;
      end
    end
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
    else
    begin
      cnt_reg <= bit_len - 1'b1;
      bit_reg <= bit_reg + 1'b1;
      if (bit_reg >= 4'd1 && bit_reg <= 4'd8)
        shift_reg <= {rx, shift_reg[7:1]};
      if (bit_reg == 4'd9)
      begin
        rx_busy_reg <= 1'b0;
        byte_ok <= 1'b1;
      end
    end
  end

  // sequence from vector fetch through jump
  always_ff @(posedge aclk)
  begin
    jump_pulse <= 1'b0;
    if (!aresetn)
    begin
      state_reg <= sbl_pkg::SBL_VEC;
      fast_reg <= 1'b1;
      wptr_reg <= '0;
    end
    else
      unique case (state_reg)
        sbl_pkg::SBL_VEC:
          if (latched_reg)
            state_reg <= mode_reg.boot_rom_enable_bit ? sbl_pkg::SBL_INIT
                                        : sbl_pkg::SBL_RUN;
        sbl_pkg::SBL_INIT: state_reg <= sbl_pkg::SBL_BAUD;
        sbl_pkg::SBL_BAUD:
          if (byte_ok)
          begin
            fast_reg <= (shift_reg == sbl_pkg::BYTE_ONES);
            state_reg <= sbl_pkg::SBL_LOAD;
          end
        // bytes into ram; host bounds length
        sbl_pkg::SBL_LOAD:
          if (byte_ok)
          begin
            ram[wptr_reg] <= shift_reg;
            wptr_reg <= wptr_reg + 1'b1;
            if (wptr_reg == len_reg)
              state_reg <= sbl_pkg::SBL_JUMP;
          end
        sbl_pkg::SBL_JUMP:
        begin
          jump_pulse <= 1'b1;
          state_reg <= sbl_pkg::SBL_RUN;
        end
        sbl_pkg::SBL_RUN: state_reg <= sbl_pkg::SBL_RUN;
      endcase
  end

  // address bit 14 low on vector fetch in special mode
  always_comb
  begin
    mem_addr = cpu_addr;
    if (vec_fetch && mode_reg.special_mode_bit)
      mem_addr[sbl_pkg::VEC_A14] = 1'b0;
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic aw_have_reg, w_have_reg;
  logic [15:0] entry_reg;
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign entry_addr = entry_reg;
  // write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sbl_pkg::RESP_OKAY;
      wr_addr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr_reg == sbl_pkg::ADDR_CTRL ||
                         wr_addr_reg == sbl_pkg::ADDR_LEN ||
                         wr_addr_reg == sbl_pkg::ADDR_ENTRY ||
                         wr_addr_reg == sbl_pkg::ADDR_CFG)
                        ? sbl_pkg::RESP_OKAY : sbl_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // length and entry registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      len_reg <= '1;
      entry_reg <= '0;
    end
    else if (wr_go && wstrb_reg[0])
    begin
      if (wr_addr_reg == sbl_pkg::ADDR_LEN)
        len_reg <= wdata_reg[AW-1:0];
      if (wr_addr_reg == sbl_pkg::ADDR_ENTRY)
        entry_reg <= wdata_reg[15:0];
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sbl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sbl_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sbl_pkg::ADDR_CTRL: s_axi_rdata <= {28'h0, mode_reg};
        sbl_pkg::ADDR_STAT: s_axi_rdata <= {28'h0,
          state_reg == sbl_pkg::SBL_RUN, state_reg == sbl_pkg::SBL_JUMP ||
          state_reg == sbl_pkg::SBL_RUN, fast_reg, mode_reg.boot_rom_enable_bit};
        sbl_pkg::ADDR_LEN: s_axi_rdata <= {{(32-AW){1'b0}}, len_reg};
        sbl_pkg::ADDR_ENTRY: s_axi_rdata <= {16'h0, entry_reg};
        sbl_pkg::ADDR_CFG: s_axi_rdata <= {24'h0, cfg_reg};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= sbl_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// file: sbl_chk.sv
// checker: port-level properties of the bootstrap loader
// assumes binding to sbl_loader, one clock domain
// ******
// checker
// ******
`timescale 1ns/1ps
module sbl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mode_pin_low,
  input wire logic mode_pin_high,
  input wire logic vec_fetch,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] entry_addr,
  input wire logic jump_pulse,
  input wire logic xbus_en,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic rel_q;
  logic spec_q;
  logic boot_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // mode given by the pins at reset release
  always_ff @(posedge aclk)
  begin
    rel_q <= !aresetn;
    if (aresetn && rel_q)
    begin
      spec_q <= !mode_pin_high;
      boot_q <= !mode_pin_high && !mode_pin_low;
    end
  end
  a_vec_alt: assert property (
    vec_fetch && !rel_q |-> mem_addr ==
    {cpu_addr[15], cpu_addr[14] && !spec_q, cpu_addr[13:0]})
    else $error("vector fetch address wrong");
  a_addr_pass: assert property (
    !vec_fetch |-> mem_addr == cpu_addr)
    else $error("plain fetch address altered");
  a_jump_once: assert property (
    jump_pulse |=> !jump_pulse [*8])
    else $error("jump pulse repeated");
  a_jump_boot: assert property (
    jump_pulse |-> boot_q && !rel_q)
    else $error("jump outside bootstrap mode");
  a_rel_clear: assert property (
    $rose(aresetn) |-> !xbus_en && !jump_pulse && entry_addr == 16'h0000)
    else $error("outputs not cleared by reset");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_wr_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
endmodule
bind sbl_loader sbl_chk u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .mode_pin_low(mode_pin_low), .mode_pin_high(mode_pin_high),
  .vec_fetch(vec_fetch), .cpu_addr(cpu_addr), .mem_addr(mem_addr),
  .entry_addr(entry_addr), .jump_pulse(jump_pulse), .xbus_en(xbus_en),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

// file: sbl_host.sv
// partner: host sending the download over the serial line
// assumes send is called right after a rising clock edge
// ******
// host model
// ******
`timescale 1ns/1ps
module sbl_host #(
  parameter int BIT = 2560
)(
  input wire logic aclk,
  output logic serial_rx
);
  // line idles at the stop level between frames
  initial serial_rx = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      serial_rx <= f[i];
      repeat (BIT) @(posedge aclk);
    end
  endtask
endmodule

// file: sbl_loader_tb.sv
// testbench: bootstrap download, mode latch and registers
// assumes sbl_loader, sbl_host and sbl_chk are compiled first
// ******
// bench
// ******
`timescale 1ns/1ps
module sbl_loader_tb;
  logic aclk, aresetn, mode_pin_low, mode_pin_high, serial_rx, vec_fetch;
  logic jump_pulse, xbus_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] cpu_addr, mem_addr, entry_addr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int error_cnt, tests_run;
  int jump_cnt = 0;
  sbl_loader DUT (
    .aclk(aclk), .aresetn(aresetn),
    .mode_pin_low(mode_pin_low), .mode_pin_high(mode_pin_high),
    .serial_rx(serial_rx), .vec_fetch(vec_fetch), .cpu_addr(cpu_addr),
    .mem_addr(mem_addr), .entry_addr(entry_addr), .jump_pulse(jump_pulse),
    .xbus_en(xbus_en), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  sbl_host #(.BIT(sbl_pkg::BIT_FAST)) host (
    .aclk(aclk),
    .serial_rx(serial_rx)
  );
  // clock, 50 ns period
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // count jump pulses
  always @(posedge aclk)
    if (jump_pulse === 1'b1) jump_cnt <= jump_cnt + 1;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] vec_exp(input logic [15:0] a, input logic s);
    return s ? a & 16'hbfff : a;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one register access, held until each channel is taken
  task automatic bus(input int w, input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    logic aw, wd, ar, dn;
    logic [1:0] r;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= (w != 0);
    s_axi_wvalid <= (w != 0);
    s_axi_bready <= (w != 0);
    s_axi_arvalid <= (w == 0);
    s_axi_rready <= (w == 0);
    do
    begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      wd = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      dn = (w != 0) ? s_axi_bvalid & s_axi_bready
                    : s_axi_rvalid & s_axi_rready;
      r = (w != 0) ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
    end while (!dn && n < 40);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // one edge passes so a following access never reassigns in this step
    @(posedge aclk);
    chk({29'h0, dn, r}, {29'h0, 1'b1, er});
  endtask
  task automatic rst();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // random addresses, vector fetch on odd steps
  task automatic vec_chk(input logic s);
    for (int i = 0; i < 4; i++)
    begin
      v = xs() | 32'h4000;
      cpu_addr <= v[15:0];
      vec_fetch <= i[0];
      @(negedge aclk);
      chk({16'h0, mem_addr}, {16'h0, vec_exp(v[15:0], s && i[0])});
      @(posedge aclk);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge aclk);
    error_cnt++;
    final_report();
  end
  initial
  begin
    {aresetn, mode_pin_low, mode_pin_high, vec_fetch, cpu_addr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_awaddr} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {error_cnt, tests_run} = '0;
    seed = 32'hc408;
    rst();
    bus(0, sbl_pkg::ADDR_CTRL, 0, sbl_pkg::RESP_OKAY);
    chk(rd, 32'h6);
    bus(0, 8'h20, 0, sbl_pkg::RESP_SLVERR);
    chk(rd, 0);
    bus(1, sbl_pkg::ADDR_LEN, 0, sbl_pkg::RESP_OKAY);
    v = xs() & 32'hffff;
    bus(1, sbl_pkg::ADDR_ENTRY, v, sbl_pkg::RESP_OKAY);
    chk({16'h0, entry_addr}, v);
    v = xs() & 32'hff;
    bus(1, sbl_pkg::ADDR_CFG, v, sbl_pkg::RESP_OKAY);
    bus(0, sbl_pkg::ADDR_CFG, 0, sbl_pkg::RESP_OKAY);
    chk(rd, v);
    vec_chk(1'b1);
    host.send(sbl_pkg::BYTE_ONES);
    // length register 0: a single byte ends the download
    v = xs();
    host.send(v[7:0]);
    repeat (sbl_pkg::BIT_FAST) @(posedge aclk);
    chk(jump_cnt, 1);
    bus(0, sbl_pkg::ADDR_STAT, 0, sbl_pkg::RESP_OKAY);
    chk(rd, 32'hf);
    bus(1, sbl_pkg::ADDR_CTRL, 32'hb, sbl_pkg::RESP_OKAY);
    bus(0, sbl_pkg::ADDR_CTRL, 0, sbl_pkg::RESP_OKAY);
    chk(rd, 32'hb);
    chk({31'h0, xbus_en}, 32'h1);
    mode_pin_high <= 1'b1;
    rst();
    bus(1, sbl_pkg::ADDR_CTRL, 32'hc, sbl_pkg::RESP_OKAY);
    bus(0, sbl_pkg::ADDR_CTRL, 0, sbl_pkg::RESP_OKAY);
    chk(rd, 32'h0);
    chk({31'h0, xbus_en}, 32'h0);
    bus(1, sbl_pkg::ADDR_CFG, 0, sbl_pkg::RESP_OKAY);
    bus(0, sbl_pkg::ADDR_CFG, 0, sbl_pkg::RESP_OKAY);
    chk(rd, {24'h0, sbl_pkg::CFG_RESET});
    vec_chk(1'b0);
    // bootstrap again: a first byte other than all ones picks slow rate
    mode_pin_high <= 1'b0;
    rst();
    repeat (4) @(posedge aclk);
    v = xs() & 32'h7f;
    host.send(v[7:0]);
    bus(0, sbl_pkg::ADDR_STAT, 0, sbl_pkg::RESP_OKAY);
    chk(rd, 32'h1);
    chk(jump_cnt, 1);
    final_report();
  end
endmodule
